// *** dv/strap_board.sv ***
// board strap resistors: each pin rests at the level its fitted resistor pulls to
// assumes the bench picks the fitted resistors through one strap_t value
`timescale 1ns/1ns
module strap_board
    import strap_pkg::*;
(
    input wire strap_pkg::strap_t fit,
    output logic mgmt_addr_strap_bit2,
    output logic mgmt_addr_strap_bit1,
    output logic mgmt_addr_strap_bit0,
    output logic broadcast_disable_strap,
    output logic [2:0] mode_strap,
    output logic autoneg_enable_strap
);
    // static levels: resistors never release, so no floating state is modelled
    assign {mgmt_addr_strap_bit2, mgmt_addr_strap_bit1, mgmt_addr_strap_bit0,
            broadcast_disable_strap, mode_strap, autoneg_enable_strap} = fit;
endmodule : strap_board

// *** dv/strap_chk.sv ***
// checker for the strap latch configuration outputs
// assumes binding onto phy_strap_option_latch, one clock domain
`timescale 1ns/1ns
module strap_chk
    import strap_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mgmt_addr_strap_bit2,
    input wire logic mgmt_addr_strap_bit1,
    input wire logic mgmt_addr_strap_bit0,
    input wire logic broadcast_disable_strap,
    input wire logic [2:0] mode_strap,
    input wire logic autoneg_enable_strap,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire strap_pkg::strap_cfg_t cfg,
    input wire logic cfg_valid
);
    wire logic [7:0] sv = {mgmt_addr_strap_bit2, mgmt_addr_strap_bit1, mgmt_addr_strap_bit0,
                           broadcast_disable_strap, mode_strap, autoneg_enable_strap};
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // capture checks only apply when the pins sat still through the sync stages
    property cap_p(ok);
        $rose(cfg_valid) && $past(sv) == $past(sv, 6) |-> ok;
    endproperty
    a_upper_zero: assert property (cfg.mgmt_addr[4:3] == ADDR_UPPER)
        else $error("upper address bits not zero");
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> cfg == '0 && !cfg_valid)
        else $error("outputs not cleared by reset");
    a_valid_rise: assert property ($rose(aresetn) |-> !cfg_valid ##[1:6] cfg_valid)
        else $error("capture not signalled in time");
    a_valid_stays: assert property (cfg_valid |=> cfg_valid)
        else $error("capture flag dropped");
    a_cfg_hold: assert property (cfg_valid && $past(cfg_valid) |->
        $stable({cfg.mgmt_addr, cfg.b2b_mode, cfg.mode_reserved}))
        else $error("captured straps changed");
    a_addr_capture: assert property (cap_p(cfg.mgmt_addr[2:0] == $past(sv[7:5])
        && cfg.autoneg_en == $past(sv[0])))
        else $error("address or autoneg capture wrong");
    a_bcast_capture: assert property (cap_p(cfg.addr0_unique == $past(sv[4])))
        else $error("broadcast strap capture wrong");
    a_mode_capture: assert property (cap_p(cfg.b2b_mode == ($past(sv[3:1]) == MODE_B2B)))
        else $error("mode decode wrong");
    cover property ($rose(cfg_valid));
    cover property (cfg.b2b_mode);
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : strap_chk
bind phy_strap_option_latch strap_chk i_strap_chk (.*);

// *** dv/tb_top.sv ***
// bench for the strap latch: board straps, resets and AXI4-Lite register access
// assumes strap_pkg, the design, strap_board and strap_chk are compiled first
`timescale 1ns/1ns
module tb_top;
    import strap_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    // readies held high: legal, and avoids re-driving them between transfers
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfg_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic mgmt_addr_strap_bit2, mgmt_addr_strap_bit1, mgmt_addr_strap_bit0;
    logic broadcast_disable_strap, autoneg_enable_strap;
    logic [2:0] mode_strap;
    strap_cfg_t cfg;
    strap_t fit = 8'h21;
    int failures = 0, num_checks = 0;
    always #4 aclk = ~aclk;
    phy_strap_option_latch i_phy_strap_option_latch (.*);
    strap_board i_strap_board (.*);
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    function automatic strap_cfg_t exp_cfg(input strap_t s);
        logic rsv;
        rsv = s.mode != MODE_MII && s.mode != MODE_B2B;
        return {ADDR_UPPER, s.addr, s.bcast_off, s.mode == MODE_B2B, rsv, s.autoneg};
    endfunction : exp_cfg
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd_reg
    task automatic rst(input strap_t s);
        fit <= s;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        chk("cfg_valid in reset", cfg_valid, 0);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("cfg_valid", cfg_valid, 1);
        chk("cfg", cfg, exp_cfg(s));
    endtask : rst
    task automatic sc_defaults;
        rst(8'h21);
        fit <= 8'hDE;
        repeat (8) @(posedge aclk);
        chk("cfg after pin change", cfg, exp_cfg(8'h21));
        rd_reg(OFF_BASIC_CONTROL);
        chk("autoneg bit", rd[BC_AUTONEG_BIT], 1);
        chk("basic rresp", rsp, RESP_OKAY);
        wr(OFF_BCAST_CONTROL, 32'h200);
        chk("bcast bresp", rsp, RESP_OKAY);
        rd_reg(OFF_STRAP_STATUS);
        chk("status rresp", rsp, RESP_OKAY);
        chk("status", rd[13:0], 14'h1801);
        chk("unique", cfg.addr0_unique, 1);
        wr(OFF_BASIC_CONTROL, 32'h0);
        rd_reg(OFF_BASIC_CONTROL);
        chk("autoneg override", rd[BC_AUTONEG_BIT], 0);
        wr(8'hFC, 32'h1);
        chk("unmapped bresp", rsp, RESP_SLVERR);
        rd_reg(8'hFC);
        chk("unmapped rdata", rd, 32'h0);
        chk("unmapped rresp", rsp, RESP_SLVERR);
    endtask : sc_defaults
    task automatic sc_codes;
        strap_t s;
        for (int m = 0; m < 8; m++) begin
            s = {3'(m), m[0], 3'(m), ~m[0]};
            rst(s);
            rd_reg(OFF_STRAP_STATUS);
            chk("status", rd[13:0], {(s.mode != MODE_MII && s.mode != MODE_B2B),
                s.bcast_off, s.autoneg,
                s.mode, 2'b00, s.bcast_off, 2'b00, s.addr});
        end
    endtask : sc_codes
    initial begin
        #20000;
        failures++;
        close_out;
    end
    initial begin
        sc_defaults;
        sc_codes;
        close_out;
    end
endmodule : tb_top

// *** inc/strap_pkg.sv ***
// package for the strap option latch: register map, field layout, reset values
// assumes a single 125 MHz clock domain and an AXI4-Lite master on the register side
package strap_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_BASIC_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STRAP_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_BCAST_CONTROL = 8'h58;
    // basic control field
    localparam int BC_AUTONEG_BIT = 12;
    // broadcast control field
    localparam int BCC_UNIQUE_BIT = 9;
    // strap status layout
    localparam int SS_ADDR_LSB = 0;
    localparam int SS_BCAST_OFF_BIT = 5;
    localparam int SS_MODE_LSB = 8;
    localparam int SS_AUTONEG_BIT = 11;
    localparam int SS_ADDR0_UNIQUE_BIT = 12;
    localparam int SS_MODE_RESERVED_BIT = 13;
    // capture reset values (strap internal defaults), fixed upper address bits, mode codes and response codes
    localparam logic [2:0] ADDR_DEFAULT = 3'h1;
    localparam logic [1:0] ADDR_UPPER = 2'h0;
    localparam logic [2:0] MODE_MII = 3'h0;
    localparam logic [2:0] MODE_B2B = 3'h6;
    localparam logic AUTONEG_DEFAULT = 1'b1;
    localparam logic BCAST_OFF_DEFAULT = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] addr;
        logic bcast_off;
        logic [2:0] mode;
        logic autoneg;
    } strap_t;

    typedef struct packed {
        logic [4:0] mgmt_addr;
        logic addr0_unique;
        logic b2b_mode;
        logic mode_reserved;
        logic autoneg_en;
    } strap_cfg_t;
endpackage : strap_pkg

// *** src/phy_strap_option_latch.sv ***
// strap option latch: captures board strap levels on reset release and exposes them
// assumes strap pins are asynchronous board levels and aresetn is the chip reset, synchronous
// Function
// - chip reset input is active low; low holds the whole block in reset
// - straps captured once at reset release; later pin changes are ignored
// - three address straps select address 0..7; default straps give address 1
// - upper management address bits [4:3] fixed at 00
// - address 0 broadcast by default; writing 1 to reg 16h bit 9 makes it unique
// - broadcast-disable strap high makes address 0 unique; low keeps broadcast
// - mode code 000 is MII, 110 is back-to-back; other codes reserved
// - autoneg strap high enables autoneg, low disables it
// - captured autoneg loaded into register 0h bit 12, software may override
`timescale 1ns/1ns
module phy_strap_option_latch
    import strap_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mgmt_addr_strap_bit2,
    input wire logic mgmt_addr_strap_bit1,
    input wire logic mgmt_addr_strap_bit0,
    input wire logic broadcast_disable_strap,
    input wire logic [2:0] mode_strap,
    input wire logic autoneg_enable_strap,
    input wire logic [strap_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [strap_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [strap_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [strap_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output strap_pkg::strap_cfg_t cfg,
    output logic cfg_valid
);
    import strap_pkg::*;

    strap_t sync1;
    strap_t sync2;
    strap_t cap;
    logic captured;
    logic autoneg_ctl;
    logic addr0_unique_sw;
    logic [ADDR_W-1:0] awaddr_q;
    logic aw_held;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held;
    strap_cfg_t next_cfg;

    function automatic logic mode_is_reserved(input logic [2:0] m);
        return (m != MODE_MII) && (m != MODE_B2B);
    endfunction : mode_is_reserved

    // register decode shared by the write response and the read response; write side effects compare offsets directly
    function automatic logic is_writable(input logic [ADDR_W-1:0] a);
        return (a == OFF_BASIC_CONTROL) || (a == OFF_BCAST_CONTROL);
    endfunction : is_writable

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return is_writable(a) || (a == OFF_STRAP_STATUS);
    endfunction : is_mapped

    // status word: raw captured levels beside the effective settings they produce,
    // so software can tell a strap choice from a later register override
    function automatic logic [DATA_W-1:0] status_word(
        input strap_t c,
        input strap_cfg_t e
    );
        logic [DATA_W-1:0] w;
        w = '0;
        w[SS_ADDR_LSB +: 5] = e.mgmt_addr;
        w[SS_BCAST_OFF_BIT] = c.bcast_off;
        w[SS_MODE_LSB +: 3] = c.mode;
        w[SS_AUTONEG_BIT] = c.autoneg;
        w[SS_ADDR0_UNIQUE_BIT] = e.addr0_unique;
        w[SS_MODE_RESERVED_BIT] = e.mode_reserved;
        return w;
    endfunction : status_word

    // two-flop synchroniser for the strap pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {mgmt_addr_strap_bit2, mgmt_addr_strap_bit1, mgmt_addr_strap_bit0,
                      broadcast_disable_strap, mode_strap, autoneg_enable_strap};
            sync2 <= sync1;
        end
    end

    // capture sequencer: the second synchroniser stage is valid only two edges after
    // release, so the first two edges are spent filling it; the third takes the sample
    typedef enum logic [1:0] {FILL_FIRST, FILL_SECOND, TAKE_SAMPLE, HOLD_CAPTURE} cap_state_t;
    cap_state_t cap_state;
    logic take;
    assign take = (cap_state == TAKE_SAMPLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_state <= FILL_FIRST;
        end else begin
            unique case (cap_state)
                FILL_FIRST: cap_state <= FILL_SECOND;
                FILL_SECOND: cap_state <= TAKE_SAMPLE;
                TAKE_SAMPLE: cap_state <= HOLD_CAPTURE;
                HOLD_CAPTURE: cap_state <= HOLD_CAPTURE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            captured <= 1'b0;
        end else if (take) begin
            captured <= 1'b1;
        end
    end

    // only reset reopens the capture; pins wiggling later never reach cap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap <= '{addr: ADDR_DEFAULT, bcast_off: BCAST_OFF_DEFAULT,
                     mode: MODE_MII, autoneg: AUTONEG_DEFAULT};
        end else if (take) begin
            cap <= sync2;
        end
    end

    always_comb begin
        next_cfg.mgmt_addr = {ADDR_UPPER, cap.addr};
        next_cfg.addr0_unique = cap.bcast_off | addr0_unique_sw;
        next_cfg.b2b_mode = (cap.mode == MODE_B2B);
        next_cfg.mode_reserved = mode_is_reserved(cap.mode);
        next_cfg.autoneg_en = autoneg_ctl;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= '0;
            cfg_valid <= 1'b0;
        end else begin
            cfg <= next_cfg;
            cfg_valid <= captured;
        end
    end

    // write channel: address and data accepted in either order
    logic wr_fire;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // unmapped writes are answered but change nothing
            s_axi_bresp <= is_writable(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // autoneg control bit: loaded from the strap at capture, software may override afterwards
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            autoneg_ctl <= AUTONEG_DEFAULT;
        end else if (take) begin
            autoneg_ctl <= sync2.autoneg;
        end else if (wr_fire && awaddr_q == OFF_BASIC_CONTROL && wstrb_q[1]) begin
            autoneg_ctl <= wdata_q[BC_AUTONEG_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr0_unique_sw <= 1'b0;
        end else if (wr_fire && awaddr_q == OFF_BCAST_CONTROL && wstrb_q[1]) begin
            addr0_unique_sw <= wdata_q[BCC_UNIQUE_BIT];
        end
    end

    // read channel: one read at a time, answered one edge after the address handshake
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        unique case (s_axi_araddr)
            OFF_BASIC_CONTROL: next_rdata[BC_AUTONEG_BIT] = autoneg_ctl;
            OFF_BCAST_CONTROL: next_rdata[BCC_UNIQUE_BIT] = addr0_unique_sw;
            OFF_STRAP_STATUS: next_rdata = status_word(cap, next_cfg);
            default: next_rdata = '0;
        endcase
    end

    // arready drops for the handshake edge and while an answer waits, so no read is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // data and response are loaded only at the handshake and stand until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end
endmodule : phy_strap_option_latch
